// ### design/result_port_pkg.sv
// Constants for the serial result port of a sigma-delta converter.
// Assumes a single 40 MHz system clock and synchronous active-high reset.
// Behaviour
// - A fresh result is produced once every conversion period of 50.54 ms.
// - The shift clock's active edge is falling; data changes after it and the host samples on the following rising edge.
// - The result output starts being driven on the falling edge of select, never before it.
// - After select rises, the result output is released to high impedance after 10 to 80 ns; the code releases it 100 ns after the synchronised select rise.
// - After the shift clock returns inactive at the end of a read, the result output goes high.
// - In master mode the device makes the shift clock with half-crystal-period phases, one bit per cycle.
// - In master mode the first active edge follows output-low by one half to one and a half crystal periods.
package result_port_pkg;
   // ==========================================
   // Timing
   localparam int CLK_PERIOD_PS = 25000;
   localparam longint CONV_PERIOD_PS = 64'd50540000000; // 50.54 ms
   localparam int CONV_CYCLES = int'(CONV_PERIOD_PS / CLK_PERIOD_PS);
   localparam int CRYSTAL_HALF_PS = 15258800; // 30.5176 us / 2
   localparam int CRYSTAL_HALF_CYCLES = CRYSTAL_HALF_PS / CLK_PERIOD_PS;
   localparam int FIRST_EDGE_HALVES = 3; // Latest first master edge, in half crystal periods
   localparam int RELEASE_PS = 80000; // Longest relinquish, rounded down
   localparam int RELEASE_CYCLES = (RELEASE_PS / CLK_PERIOD_PS) > 0 ? RELEASE_PS / CLK_PERIOD_PS : 1;
   localparam int SYNC_FILL_CYCLES = 4; // Edges after reset until a pin synchroniser shows its pin
   // ==========================================
   // Word layout
   localparam int RESULT_BITS = 24;
   localparam logic [23:0] RESULT_RESET = 24'h800000; // Offset-binary zero
endpackage

// ### design/pin_sync.sv
// Three-stage synchroniser for a pin input.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/1ps
module pin_sync #(
   parameter logic INIT = 1'b0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Pin and filtered level
   input wire logic pin,
   output logic level
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic next_level;

   // Shift and accept a change when stages two and three agree
   always_comb begin
      next_stage = {stage[1:0], pin};
      next_level = (stage[2] == stage[1]) ? stage[2] : level;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         stage <= {3{INIT}};
         level <= INIT;
      end else begin
         stage <= next_stage;
         level <= next_level;
      end
   end
endmodule

// ### design/result_port.sv
// Serial result port: conversion cadence, result shifter, master clock maker.
// Assumes select, shift clock in and mode strap are asynchronous pins.
`timescale 1ns/1ps
module result_port
   import result_port_pkg::*;
#(
   parameter int CONV_COUNT = CONV_CYCLES,
   parameter int HALF_COUNT = CRYSTAL_HALF_CYCLES,
   parameter int WIDTH = RESULT_BITS
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Converter result
   input wire logic [WIDTH-1:0] result_in,
   // Strap: high selects master mode
   input wire logic mode_master,
   // Host pins
   input wire logic sel_n,
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe_n,
   output logic dout,
   output logic dout_oe_n,
   // Status
   output logic result_ready
);
   typedef enum logic [1:0] {IDLE, WAIT_EDGE, SHIFT, DONE} shift_e;

   logic sel_n_s, sclk_s, strap_s;
   logic [31:0] conv_cnt, next_conv_cnt;
   logic [WIDTH-1:0] hold, next_hold;
   logic [WIDTH-1:0] shreg, next_shreg;
   logic [5:0] bitcnt, next_bitcnt;
   logic [15:0] half_cnt, next_half_cnt;
   logic [3:0] rel_cnt, next_rel_cnt;
   logic [2:0] fill_cnt, next_fill_cnt;
   logic [15:0] edge_wait, next_edge_wait;
   logic fresh, next_fresh;
   logic sclk_q, sel_q, master, next_master, strap_taken, next_strap_taken;
   logic next_sclk_out, next_sclk_oe_n, next_dout, next_dout_oe_n, next_ready;
   shift_e st, next_st;
   logic sclk_fall, sclk_rise, sel_fall, sel_rise, mclk_tick;

   // ==========================================
   // Pin synchronisers
   pin_sync #(.INIT(1'b1)) u_sel (.clk_sys(clk_sys), .srst(srst), .pin(sel_n), .level(sel_n_s));
   pin_sync #(.INIT(1'b1)) u_sclk (.clk_sys(clk_sys), .srst(srst), .pin(sclk_in), .level(sclk_s));
   pin_sync #(.INIT(1'b0)) u_strap (.clk_sys(clk_sys), .srst(srst), .pin(mode_master), .level(strap_s));

   // Edge detection on filtered levels
   assign sclk_fall = sclk_q & ~sclk_s;
   assign sclk_rise = ~sclk_q & sclk_s;
   assign sel_fall = sel_q & ~sel_n_s;
   assign sel_rise = ~sel_q & sel_n_s;
   assign mclk_tick = (half_cnt == 16'(HALF_COUNT - 1));

   // ==========================================
   // Next-state logic
   always_comb begin
      next_conv_cnt = conv_cnt;
      next_hold = hold;
      next_fresh = fresh;
      next_shreg = shreg;
      next_bitcnt = bitcnt;
      next_half_cnt = half_cnt;
      next_rel_cnt = rel_cnt;
      next_st = st;
      next_sclk_out = sclk_out;
      next_sclk_oe_n = sclk_oe_n;
      next_dout = dout;
      next_dout_oe_n = dout_oe_n;
      next_master = master;
      next_strap_taken = strap_taken;
      next_fill_cnt = fill_cnt;
      // strap latched once
      // The synchroniser restarts with reset, so wait until it shows the pin
      if (!strap_taken) begin
         if (fill_cnt == 3'(SYNC_FILL_CYCLES)) begin
            next_master = strap_s;
            next_strap_taken = 1'b1;
         end else begin
            next_fill_cnt = fill_cnt + 3'd1;
         end
      end
      // Cycles spent waiting for the first master edge
      next_edge_wait = (master && st == WAIT_EDGE) ? edge_wait + 16'd1 : 16'h0000;
      // Master clock phase counter
      next_half_cnt = mclk_tick ? 16'h0000 : half_cnt + 16'h0001;
      unique case (st)
         IDLE: begin
            if (sel_fall) begin
               next_dout_oe_n = 1'b0;
               next_dout = ~fresh;
               next_rel_cnt = '0;
               next_sclk_oe_n = ~master;
               next_sclk_out = 1'b1;
               if (fresh) begin
                  next_shreg = hold;
                  next_fresh = 1'b0;
                  next_bitcnt = '0;
                  next_half_cnt = '0;
                  next_st = WAIT_EDGE;
               end
            end else if (fresh && !sel_n_s && !dout_oe_n) begin
               // Result appears while already selected
               next_dout = 1'b0;
               next_shreg = hold;
               next_fresh = 1'b0;
               next_bitcnt = '0;
               next_half_cnt = '0;
               next_st = WAIT_EDGE;
            end
         end
         WAIT_EDGE, SHIFT: begin
            if (master) begin
               // half-period phases; first fall one half period after low
               if (mclk_tick) begin
                  next_sclk_out = ~sclk_out;
                  if (sclk_out) begin
                     next_dout = shreg[WIDTH-1];
                     next_shreg = {shreg[WIDTH-2:0], 1'b0};
                     next_bitcnt = bitcnt + 6'd1;
                     next_st = SHIFT;
                  end else if (bitcnt == 6'(WIDTH)) begin
                     next_st = DONE;
                  end
               end
            end else begin
               if (sclk_fall) begin
                  next_dout = shreg[WIDTH-1];
                  next_shreg = {shreg[WIDTH-2:0], 1'b0};
                  next_bitcnt = bitcnt + 6'd1;
                  next_st = SHIFT;
               end else if (sclk_rise && bitcnt == 6'(WIDTH)) begin
                  next_st = DONE;
               end
            end
         end
         DONE: begin
            // output high after clock returns inactive
            next_dout = 1'b1;
            next_sclk_out = 1'b1;
            next_st = IDLE;
         end
      endcase
      // conversion cadence
      // After the shifter, so a new result wins over a read that clears the flag
      if (conv_cnt == 32'(CONV_COUNT - 1)) begin
         next_conv_cnt = '0;
         next_hold = result_in;
         next_fresh = 1'b1;
      end else begin
         next_conv_cnt = conv_cnt + 32'd1;
      end
      if (sel_n_s && !dout_oe_n) begin
         if (sel_rise) begin
            next_rel_cnt = '0;
         end else if (rel_cnt == 4'(RELEASE_CYCLES - 1)) begin
            next_dout_oe_n = 1'b1;
            next_sclk_oe_n = 1'b1;
            next_dout = 1'b1;
            next_st = IDLE;
         end else begin
            next_rel_cnt = rel_cnt + 4'd1;
         end
      end
      next_ready = next_fresh;
   end

   // ==========================================
   // State registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         conv_cnt <= '0;
         hold <= RESULT_RESET;
         fresh <= 1'b0;
         shreg <= '0;
         bitcnt <= '0;
         half_cnt <= '0;
         rel_cnt <= '0;
         st <= IDLE;
         sclk_out <= 1'b1;
         sclk_oe_n <= 1'b1;
         dout <= 1'b1;
         dout_oe_n <= 1'b1;
         master <= 1'b0;
         strap_taken <= 1'b0;
         fill_cnt <= '0;
         edge_wait <= '0;
         sclk_q <= 1'b1;
         sel_q <= 1'b1;
         result_ready <= 1'b0;
      end else begin
         conv_cnt <= next_conv_cnt;
         hold <= next_hold;
         fresh <= next_fresh;
         shreg <= next_shreg;
         bitcnt <= next_bitcnt;
         half_cnt <= next_half_cnt;
         rel_cnt <= next_rel_cnt;
         st <= next_st;
         sclk_out <= next_sclk_out;
         sclk_oe_n <= next_sclk_oe_n;
         dout <= next_dout;
         dout_oe_n <= next_dout_oe_n;
         master <= next_master;
         strap_taken <= next_strap_taken;
         fill_cnt <= next_fill_cnt;
         edge_wait <= next_edge_wait;
         sclk_q <= sclk_s;
         sel_q <= sel_n_s;
         result_ready <= next_ready;
      end
   end

   // ==========================================
   // Checks
   AST_DRIVE_ON_SEL: assert property (@(posedge clk_sys) disable iff (srst)
      sel_fall |=> !dout_oe_n) else $error("Output not driven after select fall");
   AST_RELEASE: assert property (@(posedge clk_sys) disable iff (srst)
      (sel_rise && !dout_oe_n) |-> ##[1:4] dout_oe_n) else $error("Output not released");
   AST_NO_EARLY_DRIVE: assert property (@(posedge clk_sys) disable iff (srst)
      (sel_n_s && $past(sel_n_s) && dout_oe_n) |=> dout_oe_n) else $error("Driven while deselected");
   AST_SLAVE_SHIFT: assert property (@(posedge clk_sys) disable iff (srst)
      (!master && st == SHIFT && sclk_fall && sel_n_s == 1'b0 && !sel_rise) |=> dout == $past(shreg[WIDTH-1]))
      else $error("Data did not change on falling edge");
   AST_DONE_HIGH: assert property (@(posedge clk_sys) disable iff (srst)
      (st == DONE) |=> dout) else $error("Output not high after read");
   AST_MCLK_PHASE: assert property (@(posedge clk_sys) disable iff (srst)
      (master && !sclk_oe_n && $changed(sclk_out) && st == SHIFT) |-> half_cnt == 16'h0000)
      else $error("Master clock phase wrong");
   AST_STRAP_FIXED: assert property (@(posedge clk_sys) disable iff (srst)
      strap_taken |=> $stable(master)) else $error("Mode changed");
   AST_CADENCE: assert property (@(posedge clk_sys) disable iff (srst)
      (conv_cnt == 32'(CONV_COUNT - 1)) |=> (fresh && conv_cnt == 32'd0)) else $error("Cadence wrong");
   AST_FIRST_EDGE: assert property (@(posedge clk_sys) disable iff (srst)
      (master && st == WAIT_EDGE) |-> edge_wait < 16'(FIRST_EDGE_HALVES * HALF_COUNT))
      else $error("First master edge late");
   AST_FIRST_EDGE_EARLY: assert property (@(posedge clk_sys) disable iff (srst)
      (master && st == SHIFT && $past(st) == WAIT_EDGE) |-> $past(edge_wait) >= 16'(HALF_COUNT - 1))
      else $error("First master edge early");
endmodule

// ### testbench/host_model.sv
// Host model: drives select and shift clock, reads result words.
// Assumes result_port pins and the clk_sys of the bench.
`timescale 1ns/1ps
module host_model #(
   parameter int HALF = 8
) (
   // Clock and strap
   input wire logic clk_sys,
   input wire logic mode_master,
   // Device pins
   input wire logic dout,
   input wire logic dout_oe_n,
   input wire logic sclk_out,
   input wire logic sclk_oe_n,
   output logic sel_n,
   output logic sclk_in
);
   // ==========================================
   // Line level: a released line shows the inverse of its last value
   logic last = 1'b0;
   wire logic dl;
   assign dl = dout_oe_n ? ~last : dout;
   always @(posedge clk_sys) if (!dout_oe_n) last <= dout;
   initial begin
      sel_n = 1'b1;
      sclk_in = 1'b1;
   end
   // ==========================================
   // Select, wait for ready low, shift nbits
   task automatic read_word(input int nbits, input int tmax, output logic [23:0] w, output int gap, output int lowp,
                            output bit ok);
      int n;
      ok = 1;
      gap = 0;
      lowp = 0;
      w = 24'h000000;
      @(negedge clk_sys) sel_n <= 1'b0;
      // Low line means ready
      // A floating line may show low; only a driven low counts as the flag
      n = 0;
      while (!(dout_oe_n === 1'b0 && dl === 1'b0) && n < tmax) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= tmax) ok = 0;
      for (int i = 0; i < nbits && ok; i++) begin
         n = 0;
         if (mode_master) begin
            while (!(sclk_oe_n === 1'b0 && sclk_out === 1'b0) && n < 4*HALF) begin
               @(negedge clk_sys);
               n++;
            end
            if (i == 0) gap = n;
            if (n >= 4*HALF) ok = 0;
            n = 0;
            while (sclk_out !== 1'b1 && n < 4*HALF) begin
               @(negedge clk_sys);
               n++;
            end
            if (i == 0) lowp = n;
            if (n >= 4*HALF) ok = 0;
         end else begin
            // Falling edge active, phases of 200 ns
            sclk_in <= 1'b0;
            repeat (8) @(negedge clk_sys);
            sclk_in <= 1'b1;
         end
         w = {w[22:0], dl};
         if (!mode_master) repeat (8) @(negedge clk_sys);
      end
      repeat (8) @(negedge clk_sys);
   endtask
   // Clock already high when select rises
   task automatic release_sel(output int rel);
      @(negedge clk_sys) sel_n <= 1'b1;
      rel = 0;
      while (dout_oe_n !== 1'b1 && rel < 20) begin
         @(negedge clk_sys);
         rel++;
      end
   endtask
endmodule

// ### testbench/test_adc_serial_result_port.sv
// Bench for result_port: row table of reads in both modes, then refusal and abort.
// Assumes host_model and the result_port_pkg constants.
`timescale 1ns/1ps
module test_adc_serial_result_port;
   import result_port_pkg::*;
   localparam int CONV = 2000;
   localparam int HALF = 8;
   typedef struct {logic mode; logic [23:0] val; logic [23:0] exp;} row_s;
   row_s rows[4] = '{'{1'b0, 24'ha5c3e1, 24'ha5c3e1}, '{1'b1, 24'h5a3c96, 24'h5a3c96},
                     '{1'b1, 24'h000001, 24'h000001}, '{1'b0, 24'hfffffe, 24'hfffffe}};
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic mode_master = 1'b0;
   logic [23:0] result_in = 24'h000000;
   logic sel_n, sclk_in, sclk_out, sclk_oe_n, dout, dout_oe_n, result_ready;
   logic [23:0] w;
   int n_mismatch = 0;
   int cmp_count = 0;
   int gap, lowp, rel, n;
   bit ok;
   result_port #(.CONV_COUNT(CONV), .HALF_COUNT(HALF), .WIDTH(24)) result_port_i (.clk_sys(clk_sys), .srst(srst),
      .result_in(result_in), .mode_master(mode_master), .sel_n(sel_n), .sclk_in(sclk_in), .sclk_out(sclk_out),
      .sclk_oe_n(sclk_oe_n), .dout(dout), .dout_oe_n(dout_oe_n), .result_ready(result_ready));
   host_model #(.HALF(HALF)) host_model_i (.clk_sys(clk_sys), .mode_master(mode_master), .dout(dout),
      .dout_oe_n(dout_oe_n), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .sel_n(sel_n), .sclk_in(sclk_in));
   // ==========================================
   // Clock and compare tasks
   initial forever #12.5 clk_sys = ~clk_sys;
   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t word got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_span(input int got, input int lo, input int hi);
      cmp_count++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task automatic close_out();
      $display("Counts: %0d mismatches in %0d compares", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Reset with the strap held steady
   task automatic do_reset(input logic m);
      @(negedge clk_sys) mode_master <= m;
      srst <= 1'b1;
      repeat (6) @(negedge clk_sys);
      chk_bit(dout_oe_n & sclk_oe_n & dout & ~result_ready, 1'b1);
      srst <= 1'b0;
      repeat (5) @(negedge clk_sys);
   endtask
   task automatic wait_ready();
      n = 0;
      while (result_ready !== 1'b1 && n < CONV + 100) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= CONV + 100) begin
         n_mismatch++;
         $display("[ERR] %0t no result", $time);
         close_out();
      end
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (2) @(negedge clk_sys);
      foreach (rows[k]) begin
         do_reset(rows[k].mode);
         result_in <= rows[k].val;
         wait_ready();
         chk_span(n, CONV - 30, CONV + 10);
         chk_bit(dout_oe_n, 1'b1);
         host_model_i.read_word(24, 40, w, gap, lowp, ok);
         chk_bit(ok, 1'b1);
         chk_word(w, rows[k].exp);
         chk_bit(dout, 1'b1);
         chk_bit(result_ready, 1'b0);
         chk_bit(sclk_oe_n, ~rows[k].mode);
         if (rows[k].mode) begin
            chk_span(gap, HALF, 3*HALF);
            chk_span(lowp, HALF, HALF);
         end
         host_model_i.release_sel(rel);
         chk_span(rel, 1, 8);
      end
      // Stale result is refused: line stays high while selected
      host_model_i.read_word(0, 40, w, gap, lowp, ok);
      chk_bit(ok, 1'b0);
      chk_bit(dout | dout_oe_n, 1'b1);
      host_model_i.release_sel(rel);
      chk_span(rel, 1, 8);
      // Abort in mid-word, output released promptly
      result_in <= 24'h3c3c3c;
      wait_ready();
      host_model_i.read_word(5, 40, w, gap, lowp, ok);
      chk_word(w, 24'h000007);
      host_model_i.release_sel(rel);
      chk_span(rel, 1, 8);
      // Result that lands while already selected drops the line at once
      result_in <= 24'h96a53c;
      host_model_i.read_word(24, CONV + 100, w, gap, lowp, ok);
      chk_bit(ok, 1'b1);
      chk_word(w, 24'h96a53c);
      host_model_i.release_sel(rel);
      chk_span(rel, 1, 8);
      close_out();
   end
endmodule
